// File: hw/rtbd_core.v
// rtbd_core.v - real-time breakpoint triggers, emulator mode, status pins
// assumes: core strobes are one-cycle pulses on CLOCK; the serial link
// clock is sampled, the link decoder posts register writes/reads as strobes
`timescale 1ns/1ns
`default_nettype none
`include "rtbd_defs.vh"
module rtbd_core
#(
   parameter AW = 32,
   parameter DW = 32
)
(
   // clock and reset
   input  wire          CLOCK,
   input  wire          RSTN,
   // register port (core debug write and link decoder share it)
   input  wire [3:0]    REG_ADDR,
   input  wire [31:0]   REG_WDATA,
   input  wire          REG_WR,
   input  wire          REG_RD,
   input  wire          REG_FROM_LINK,
   output reg  [31:0]   REG_RDATA,
   // serial link clock pin
   input  wire          DEBUG_SERIAL_CLOCK,
   output wire          LINK_CLK_EDGE,
   // core instruction stream
   input  wire          INSN_START,
   input  wire [AW-1:0] INSN_PC,
   input  wire          INSN_DONE,
   input  wire          OPND_VALID,
   input  wire [1:0]    OPND_SIZE,
   input  wire [31:0]   OPND_DATA,
   input  wire          TRACE_EXC,
   input  wire          RETURN_FROM_EXCEPTION,
   input  wire          RESET_INPUT_N,
   input  wire          RESET_EXC_START,
   input  wire [2:0]    IRQ_LEVEL,
   // local bus observed for breakpoints
   input  wire          BUS_VALID,
   input  wire [AW-1:0] BUS_ADDR,
   input  wire [DW-1:0] BUS_DATA,
   input  wire          BUS_IDLE,
   // debug bus requests from the link decoder
   input  wire          DBG_MEM_REQ,
   input  wire          DBG_REG_REQ,
   input  wire          DBG_CYCLE_DONE,
   output reg           DBG_BUS_GRANT,
   output wire          FETCH_STALL,
   output wire          DBG_REG_OK,
   // core control
   output wire          PC_BREAK,
   output reg           CORE_HALT,
   output wire          TAKE_DEBUG_IRQ,
   output wire          IRQ_ACCEPT,
   output reg  [7:0]    EXC_VECTOR,
   output reg  [3:0]    EXC_FRAME_BYTES,
   output reg           EMU_MODE,
   output wire          CACHE_SRAM_OFF,
   output wire [1:0]    TRANSFER_TYPE,
   output wire [2:0]    TRANSFER_MODIFIER,
   output wire          EMU_SPACE,
   input  wire          ACCESS_IS_CODE,
   // status pins
   output reg  [3:0]    PROCESSOR_STATUS_OUT,
   output reg  [3:0]    DEBUG_DATA_OUT
);
   localparam ST_RUN = 2'h0;
   localparam ST_ENT = 2'h1;
   localparam ST_EMU = 2'h2;
   localparam ST_HLT = 2'h3;

   reg  [31:0] cfg;
   reg  [7:0]  trig;
   reg  [AW-1:0] pc_val;
   reg  [AW-1:0] pc_msk;
   reg  [AW-1:0] a_lo;
   reg  [AW-1:0] a_hi;
   reg  [DW-1:0] d_val;
   reg  [DW-1:0] d_msk;
   reg  [3:0]  bstate;
   reg  [1:0]  state;
   reg  [2:0]  ent_cnt;
   reg         pend;
   reg         suppress;
   reg         exit_show;
   reg         sclk_s1;
   reg         sclk_s2;
   reg         sclk_d;
   wire        hit_pc;
   wire        hit_a;
   wire        hit_d;
   wire [2:0]  l1_en;
   wire [2:0]  l2_en;
   wire [1:0]  resp;
   wire        l1_hit;
   wire        l2_hit;
   wire        fire_bus;
   wire        fire_pc;
   wire        wr_trig;
   wire        rd_cfg;
   wire [31:0] cfg_view;
   reg  [3:0]  next_bstate;

   assign l1_en = trig[`RTBD_TRG_L1_HI:`RTBD_TRG_L1_LO];
   assign l2_en = trig[`RTBD_TRG_L2_HI:`RTBD_TRG_L2_LO];
   assign resp  = trig[`RTBD_TRG_RESP_HI:`RTBD_TRG_RESP_LO];

   // the three comparators: pc with mask, address range, data with mask
   rtbd_match #(.W(AW), .RANGE(0)) u_pc
   (
      .clk   (CLOCK),
      .rstn  (RSTN),
      .valid (INSN_START),
      .value (INSN_PC),
      .ref_a (pc_val),
      .ref_b (pc_msk),
      .hit   (hit_pc)
   );
   rtbd_match #(.W(AW), .RANGE(1)) u_addr
   (
      .clk   (CLOCK),
      .rstn  (RSTN),
      .valid (BUS_VALID),
      .value (BUS_ADDR),
      .ref_a (a_lo),
      .ref_b (a_hi),
      .hit   (hit_a)
   );
   rtbd_match #(.W(DW), .RANGE(0)) u_data
   (
      .clk   (CLOCK),
      .rstn  (RSTN),
      .valid (BUS_VALID),
      .value (BUS_DATA),
      .ref_a (d_val),
      .ref_b (d_msk),
      .hit   (hit_d)
   );

   // a level fires when any enabled kind hits; suppressed after a return
   assign l1_hit = ~suppress & (|(l1_en & {hit_d, hit_a, hit_pc}));
   assign l2_hit = ~suppress & (|(l2_en & {hit_d, hit_a, hit_pc}));

   // final trigger: single level on level one, two level only on level two
   assign fire_bus = (bstate == `RTBD_BST_W1 && l2_en == 3'h0 && l1_hit) ||
                     (bstate == `RTBD_BST_W2 && l2_hit);
   // pc hit is reported the cycle after INSN_START, once the registered match is out, so the core can stop early
   assign fire_pc = fire_bus & hit_pc;

   assign wr_trig = REG_WR && REG_ADDR == `RTBD_REG_TRIG;
   assign rd_cfg  = REG_RD && REG_ADDR == `RTBD_REG_CFG;

   // breakpoint state sequencer
   always @*
   begin
      next_bstate = bstate;
      if (wr_trig)
         next_bstate = (REG_WDATA[`RTBD_TRG_L1_HI:`RTBD_TRG_L1_LO] != 3'h0)
                       ? `RTBD_BST_W1 : `RTBD_BST_NONE;
      else if (bstate == `RTBD_BST_W1 && l1_hit)
         next_bstate = (l2_en != 3'h0) ? `RTBD_BST_W2 : `RTBD_BST_T1;
      else if (bstate == `RTBD_BST_W2 && l2_hit)
         next_bstate = `RTBD_BST_T2;
      else if (rd_cfg && (bstate == `RTBD_BST_T2 ||
               (bstate == `RTBD_BST_T1 && l2_en == 3'h0)))
         next_bstate = `RTBD_BST_NONE;
   end

   // register writes; link and core debug write both land here
   always @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         cfg    <= 32'h00000000;
         trig   <= 8'h00;
         pc_val <= {AW{1'b0}};
         pc_msk <= {AW{1'b0}};
         a_lo   <= {AW{1'b0}};
         a_hi   <= {AW{1'b0}};
         d_val  <= {DW{1'b0}};
         d_msk  <= {DW{1'b0}};
         bstate <= `RTBD_BST_NONE;
      end
      else
      begin
         bstate <= next_bstate;
         if (REG_WR)
         begin
            if (REG_ADDR == `RTBD_REG_CFG)
               cfg <= REG_WDATA;
            else if (REG_ADDR == `RTBD_REG_TRIG)
               trig <= REG_WDATA[7:0];
            else if (REG_ADDR == `RTBD_REG_PC)
               pc_val <= REG_WDATA[AW-1:0];
            else if (REG_ADDR == `RTBD_REG_PCMASK)
               pc_msk <= REG_WDATA[AW-1:0];
            else if (REG_ADDR == `RTBD_REG_ALO)
               a_lo <= REG_WDATA[AW-1:0];
            else if (REG_ADDR == `RTBD_REG_AHI)
               a_hi <= REG_WDATA[AW-1:0];
            else if (REG_ADDR == `RTBD_REG_DATA)
               d_val <= REG_WDATA[DW-1:0];
            else if (REG_ADDR == `RTBD_REG_DMASK)
               d_msk <= REG_WDATA[DW-1:0];
         end
      end
   end

   // config view: stored bits with live state and emulator/halt flags
   assign cfg_view = {cfg[31:9], CORE_HALT, EMU_MODE, cfg[6:4], bstate};

   // reads: the link sees only config/status, the core sees everything
   always @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
         REG_RDATA <= 32'h00000000;
      else if (REG_RD)
      begin
         if (REG_ADDR == `RTBD_REG_CFG)
            REG_RDATA <= cfg_view;
         else if (REG_FROM_LINK)
            REG_RDATA <= 32'h00000000;
         else if (REG_ADDR == `RTBD_REG_TRIG)
            REG_RDATA <= {24'h000000, trig};
         else if (REG_ADDR == `RTBD_REG_PC)
            REG_RDATA <= pc_val;
         else if (REG_ADDR == `RTBD_REG_PCMASK)
            REG_RDATA <= pc_msk;
         else if (REG_ADDR == `RTBD_REG_ALO)
            REG_RDATA <= a_lo;
         else if (REG_ADDR == `RTBD_REG_AHI)
            REG_RDATA <= a_hi;
         else if (REG_ADDR == `RTBD_REG_DATA)
            REG_RDATA <= d_val;
         else if (REG_ADDR == `RTBD_REG_DMASK)
            REG_RDATA <= d_msk;
         else
            REG_RDATA <= 32'h00000000;
      end
   end

   // serial link clock: two-stage sync, then rising edge detect
   always @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_d  <= 1'b0;
      end
      else
      begin
         sclk_s1 <= DEBUG_SERIAL_CLOCK;
         sclk_s2 <= sclk_s1;
         sclk_d  <= sclk_s2;
      end
   end
   assign LINK_CLK_EDGE = sclk_s2 & ~sclk_d;

   // interrupt-response trigger is held until the instruction sample point
   // a pc hit is taken at once, before its instruction runs; bus hits wait
   assign TAKE_DEBUG_IRQ = (((pend | (fire_bus & resp == `RTBD_RESP_IRQ)) & INSN_START)
                           | PC_BREAK) & state == ST_RUN;
   assign PC_BREAK = fire_pc & resp == `RTBD_RESP_IRQ;
   // debug interrupt outranks level seven; emulator mode blocks all
   assign IRQ_ACCEPT = (IRQ_LEVEL != 3'h0) & ~EMU_MODE & ~TAKE_DEBUG_IRQ;

   // pending hit, halt, emulator state and suppression window
   always @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         pend            <= 1'b0;
         CORE_HALT       <= 1'b0;
         EMU_MODE        <= 1'b0;
         state           <= ST_RUN;
         ent_cnt         <= 3'h0;
         suppress        <= 1'b0;
         exit_show       <= 1'b0;
         EXC_VECTOR      <= 8'h00;
         EXC_FRAME_BYTES <= 4'h0;
      end
      else
      begin
         exit_show <= 1'b0;
         if (TAKE_DEBUG_IRQ)
            pend <= 1'b0;
         else if (fire_bus && resp == `RTBD_RESP_IRQ)
            pend <= 1'b1;
         if (suppress && INSN_DONE)
            suppress <= 1'b0;
         case (state)
            ST_RUN:
            begin
               if (fire_bus && resp == `RTBD_RESP_HALT)
               begin
                  CORE_HALT <= 1'b1;
                  state     <= ST_HLT;
               end
               else if (TAKE_DEBUG_IRQ ||
                        (TRACE_EXC && cfg[`RTBD_CFG_TDE]) ||
                        (RESET_EXC_START && RESET_INPUT_N && cfg[`RTBD_CFG_EMUF]))
               begin
                  EMU_MODE        <= 1'b1;
                  state           <= ST_ENT;
                  ent_cnt         <= `RTBD_PST_ENTRY_CYC;
                  EXC_VECTOR      <= `RTBD_VEC_DEBUG;
                  EXC_FRAME_BYTES <= `RTBD_FRAME_BYTES;
               end
            end
            ST_ENT:
            begin
               ent_cnt <= ent_cnt - 3'h1;
               if (ent_cnt == 3'h1)
                  state <= ST_EMU;
            end
            ST_EMU:
            begin
               if (RETURN_FROM_EXCEPTION)
               begin
                  EMU_MODE  <= 1'b0;
                  exit_show <= 1'b1;
                  suppress  <= 1'b1;
                  state     <= ST_RUN;
               end
            end
            default:
            begin
               // the flag may be set while halted; reset start with RESET_INPUT_N high clears halt
               if (RESET_EXC_START && RESET_INPUT_N)
               begin
                  CORE_HALT <= 1'b0;
                  EMU_MODE  <= cfg[`RTBD_CFG_EMUF];
                  state     <= cfg[`RTBD_CFG_EMUF] ? ST_EMU : ST_RUN;
               end
            end
         endcase
      end
   end

   // emulator address space when region select is set
   assign EMU_SPACE         = EMU_MODE & cfg[`RTBD_CFG_MAP];
   assign CACHE_SRAM_OFF    = EMU_SPACE;
   assign TRANSFER_TYPE     = EMU_SPACE ? `RTBD_TT_EMU : 2'h0;
   assign TRANSFER_MODIFIER = ~EMU_SPACE ? 3'h0 :
                              ACCESS_IS_CODE ? `RTBD_TM_EMU_CODE : `RTBD_TM_EMU_DATA;

   // local bus hand-off for memory commands; register commands need a stop
   assign FETCH_STALL = DBG_MEM_REQ | DBG_BUS_GRANT;
   assign DBG_REG_OK  = DBG_REG_REQ & (CORE_HALT | state == ST_HLT);
   always @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
         DBG_BUS_GRANT <= 1'b0;
      else if (DBG_BUS_GRANT && DBG_CYCLE_DONE)
         DBG_BUS_GRANT <= 1'b0;
      else if (DBG_MEM_REQ && BUS_IDLE)
         DBG_BUS_GRANT <= 1'b1;
   end

   // status pins: entry/exit/halt codes win, then markers, then state
   always @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         PROCESSOR_STATUS_OUT <= `RTBD_PST_IDLE;
         DEBUG_DATA_OUT       <= `RTBD_DD_NONE;
      end
      else
      begin
         if (state == ST_ENT)
            PROCESSOR_STATUS_OUT <= `RTBD_PST_ENTRY;
         else if (exit_show)
            PROCESSOR_STATUS_OUT <= `RTBD_PST_EXIT;
         else if (CORE_HALT)
            PROCESSOR_STATUS_OUT <= `RTBD_PST_HALT;
         else if (OPND_VALID)
            PROCESSOR_STATUS_OUT <= (OPND_SIZE == 2'h0) ? `RTBD_PST_BYTE :
                                    (OPND_SIZE == 2'h1) ? `RTBD_PST_WORD
                                                        : `RTBD_PST_LONG;
         else if (INSN_DONE)
            PROCESSOR_STATUS_OUT <= `RTBD_PST_INSN;
         else
            PROCESSOR_STATUS_OUT <= `RTBD_PST_IDLE;
         if (OPND_VALID)
            DEBUG_DATA_OUT <= OPND_DATA[3:0];
         else if (bstate == `RTBD_BST_W1)
            DEBUG_DATA_OUT <= `RTBD_DD_W1;
         else if (bstate == `RTBD_BST_T1)
            DEBUG_DATA_OUT <= `RTBD_DD_T1;
         else if (bstate == `RTBD_BST_W2)
            DEBUG_DATA_OUT <= `RTBD_DD_W2;
         else if (bstate == `RTBD_BST_T2)
            DEBUG_DATA_OUT <= `RTBD_DD_T2;
         else
            DEBUG_DATA_OUT <= `RTBD_DD_NONE;
      end
   end
endmodule
`default_nettype wire

// File: hw/rtbd_defs.vh
// rtbd_defs.vh - constants of the real-time breakpoint debug block
// assumes: included by bare name from the design files under hw/
`ifndef RTBD_DEFS_VH
`define RTBD_DEFS_VH
// register indices on the plain register port
`define RTBD_REG_CFG      4'h0
`define RTBD_REG_TRIG     4'h1
`define RTBD_REG_PC       4'h2
`define RTBD_REG_PCMASK   4'h3
`define RTBD_REG_ALO      4'h4
`define RTBD_REG_AHI      4'h5
`define RTBD_REG_DATA     4'h6
`define RTBD_REG_DMASK    4'h7
// debug_config_status field positions
`define RTBD_CFG_BST_LO   0
`define RTBD_CFG_BST_HI   3
`define RTBD_CFG_EMUF     4
`define RTBD_CFG_TDE      5
`define RTBD_CFG_MAP      6
`define RTBD_CFG_EMUST    7
`define RTBD_CFG_HALT     8
// trigger_definition_reg field positions
`define RTBD_TRG_RESP_LO  0
`define RTBD_TRG_RESP_HI  1
`define RTBD_TRG_L1_LO    2
`define RTBD_TRG_L1_HI    4
`define RTBD_TRG_L2_LO    5
`define RTBD_TRG_L2_HI    7
// breakpoint state field codes
`define RTBD_BST_NONE     4'h0
`define RTBD_BST_W1       4'h1
`define RTBD_BST_T1       4'h2
`define RTBD_BST_W2       4'h5
`define RTBD_BST_T2       4'h6
// debug data pin codes for the same states
`define RTBD_DD_NONE      4'h0
`define RTBD_DD_W1        4'h2
`define RTBD_DD_T1        4'h4
`define RTBD_DD_W2        4'hA
`define RTBD_DD_T2        4'hC
// trigger response codes
`define RTBD_RESP_HALT    2'h1
`define RTBD_RESP_IRQ     2'h2
// processor status codes
`define RTBD_PST_IDLE     4'h0
`define RTBD_PST_INSN     4'h1
`define RTBD_PST_EXIT     4'h7
`define RTBD_PST_BYTE     4'h8
`define RTBD_PST_WORD     4'h9
`define RTBD_PST_LONG     4'hB
`define RTBD_PST_ENTRY    4'hD
`define RTBD_PST_HALT     4'hF
// exception and emulator space constants
`define RTBD_VEC_DEBUG    8'h0C
`define RTBD_FRAME_BYTES  4'h8
`define RTBD_TT_EMU       2'h2
`define RTBD_TM_EMU_DATA  3'h5
`define RTBD_TM_EMU_CODE  3'h6
`define RTBD_PST_ENTRY_CYC 3'h4
`endif

// File: hw/rtbd_match.v
// rtbd_match.v - one comparator: masked equality or inclusive range
// assumes: inputs are from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module rtbd_match
#(
   parameter W     = 32,
   parameter RANGE = 0
)
(
   // clock and reset
   input  wire         clk,
   input  wire         rstn,
   // compare inputs
   input  wire         valid,
   input  wire [W-1:0] value,
   input  wire [W-1:0] ref_a,
   input  wire [W-1:0] ref_b,
   // result
   output reg          hit
);
   wire cmp;
   // ref_b is a mask (1 = ignore bit) or, in range mode, the upper bound
   assign cmp = RANGE ? ((value >= ref_a) && (value <= ref_b))
                      : (((value ^ ref_a) & ~ref_b) == {W{1'b0}});
   // registered so the long compare never sits in the core's path
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         hit <= 1'b0;
      else
         hit <= valid & cmp;
   end
endmodule
`default_nettype wire

// File: test/rtbd_checker.sv
// rtbd_checker.sv - port-level timing checks for the breakpoint debug block
// assumes: bound to rtbd_core, one clock domain, async active-low reset
`timescale 1ns/1ns
`default_nettype none
module rtbd_checker
(
   // clock and reset
   input wire logic       CLOCK,
   input wire logic       RSTN,
   // core control
   input wire logic       CORE_HALT,
   input wire logic       TAKE_DEBUG_IRQ,
   input wire logic       IRQ_ACCEPT,
   input wire logic       EMU_MODE,
   input wire logic       RETURN_FROM_EXCEPTION,
   input wire logic [7:0] EXC_VECTOR,
   input wire logic [3:0] EXC_FRAME_BYTES,
   // emulator space
   input wire logic       EMU_SPACE,
   input wire logic       CACHE_SRAM_OFF,
   input wire logic [1:0] TRANSFER_TYPE,
   input wire logic [2:0] TRANSFER_MODIFIER,
   input wire logic       ACCESS_IS_CODE,
   // debug bus
   input wire logic       DBG_MEM_REQ,
   input wire logic       BUS_IDLE,
   input wire logic       DBG_BUS_GRANT,
   input wire logic       FETCH_STALL,
   input wire logic       DBG_CYCLE_DONE,
   // status pins
   input wire logic [3:0] PROCESSOR_STATUS_OUT
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);

   // entry code must stand long enough for a trace probe to catch it
   sequence entry_s;
      (EMU_MODE && PROCESSOR_STATUS_OUT == 4'hD) [*4];
   endsequence
   sequence exit_s;
      !EMU_MODE ##1 PROCESSOR_STATUS_OUT == 4'h7;
   endsequence

   halt_status_a: assert property ($rose(CORE_HALT) |=> PROCESSOR_STATUS_OUT == 4'hF)
      else $error("halt without status F");
   irq_entry_a: assert property (TAKE_DEBUG_IRQ |=> ##1 entry_s)
      else $error("debug entry sequence wrong");
   entry_vector_a: assert property (TAKE_DEBUG_IRQ |-> ##[1:8]
      (EXC_VECTOR == 8'h0C && EXC_FRAME_BYTES == 4'h8))
      else $error("debug vector or frame size wrong");
   emu_no_irq_a: assert property (EMU_MODE |-> !IRQ_ACCEPT && !TAKE_DEBUG_IRQ)
      else $error("interrupt accepted in emulator mode");
   emu_exit_a: assert property (RETURN_FROM_EXCEPTION && EMU_MODE |=> exit_s)
      else $error("emulator exit wrong");
   emu_space_a: assert property (EMU_SPACE |-> EMU_MODE && CACHE_SRAM_OFF
      && TRANSFER_TYPE == 2'h2 && TRANSFER_MODIFIER == (ACCESS_IS_CODE ? 3'h6 : 3'h5))
      else $error("emulator space attributes wrong");
   grant_cause_a: assert property ($rose(DBG_BUS_GRANT) |->
      $past(DBG_MEM_REQ && BUS_IDLE) && FETCH_STALL)
      else $error("bus granted without request or idle bus");
   grant_drop_a: assert property (DBG_BUS_GRANT && DBG_CYCLE_DONE |=> !DBG_BUS_GRANT)
      else $error("bus not reclaimed");
endmodule
bind rtbd_core rtbd_checker chk (.*);
`default_nettype wire

// File: test/rtbd_link_model.sv
// rtbd_link_model.sv - development system end of the serial debug link
// assumes: the bench calls frame() before each link-side register access
`timescale 1ns/1ns
`default_nettype none
module rtbd_link_model
(
   // core-side register write in progress
   input wire logic core_wr,
   // serial link clock
   output var logic sclk
);
   int sent;
   initial
   begin
      sclk = 1'b0;
      sent = 0;
   end
   // clock idles low between frames, 125 ns period, phase unrelated to the core
   task automatic frame();
      for (int i = 0; i < 20 && core_wr === 1'b1; i++) #7;
      #3;
      repeat (4)
      begin
         sclk = 1'b1;
         #63;
         sclk = 1'b0;
         #62;
         sent++;
      end
   endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// testbench.sv - self-checking bench for the real-time breakpoint debug block
// assumes: rtbd_core and rtbd_defs.vh under hw/, checker bound, link model
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic [31:0] REG_WDATA = 32'h0, INSN_PC = 32'h0, OPND_DATA = 32'h0;
   logic [31:0] BUS_ADDR = 32'h0, BUS_DATA = 32'h0, exp_q[$];
   logic [3:0]  REG_ADDR = 4'h0, pst_x = 4'h0, dd_x = 4'h0;
   logic [2:0]  IRQ_LEVEL = 3'h0;
   logic [1:0]  OPND_SIZE = 2'h0;
   logic [7:0]  pls = 8'h0, edges = 8'h0;
   logic        CLOCK = 1'b0, RSTN = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, REG_FROM_LINK = 1'b0;
   logic        RESET_INPUT_N = 1'b1, BUS_IDLE = 1'b1, DBG_MEM_REQ = 1'b0, DBG_REG_REQ = 1'b0;
   logic        ACCESS_IS_CODE = 1'b0, rd_d = 1'b0;
   wire  [31:0] REG_RDATA;
   wire  [7:0]  EXC_VECTOR;
   wire  [3:0]  EXC_FRAME_BYTES, PROCESSOR_STATUS_OUT, DEBUG_DATA_OUT;
   wire  [2:0]  TRANSFER_MODIFIER;
   wire  [1:0]  TRANSFER_TYPE;
   wire         LINK_CLK_EDGE, DBG_BUS_GRANT, FETCH_STALL, DBG_REG_OK, PC_BREAK, CORE_HALT;
   wire         TAKE_DEBUG_IRQ, IRQ_ACCEPT, EMU_MODE, CACHE_SRAM_OFF, EMU_SPACE, sclk;
   wire  [5:0]  probe = {DEBUG_DATA_OUT === dd_x, PROCESSOR_STATUS_OUT === pst_x,
                         !EMU_MODE, DBG_BUS_GRANT, EMU_MODE, CORE_HALT};
   int          error_cnt = 0, cmp_count = 0;

   rtbd_link_model lm (.core_wr(REG_WR && !REG_FROM_LINK), .sclk(sclk));
   rtbd_core dut (.*, .DEBUG_SERIAL_CLOCK(sclk), .INSN_START(pls[0]), .INSN_DONE(pls[1]),
      .OPND_VALID(pls[2]), .TRACE_EXC(pls[3]), .RETURN_FROM_EXCEPTION(pls[4]),
      .RESET_EXC_START(pls[5]), .BUS_VALID(pls[6]), .DBG_CYCLE_DONE(pls[7]));

   // 100 MHz core clock
   always #5 CLOCK = ~CLOCK;

   // read data stands from the cycle after the strobe until the next read; link edges counted
   always @(posedge CLOCK)
   begin
      if (rd_d === 1'b1)
         cmp_rd(REG_RDATA, exp_q.pop_front());
      rd_d <= REG_RD;
      if (LINK_CLK_EDGE === 1'b1)
         edges <= edges + 8'h1;
   end

   task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: pin %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // one register access; link accesses are preceded by a serial frame
   task automatic bus(input logic lk, input logic w, input logic [3:0] a, input logic [31:0] d);
      if (lk)
         lm.frame();
      @(posedge CLOCK);
      REG_FROM_LINK <= lk;
      REG_ADDR <= a;
      REG_WDATA <= w ? d : 32'h0;
      REG_WR <= w;
      REG_RD <= !w;
      if (!w)
         exp_q.push_back(d);
      @(posedge CLOCK);
      REG_WR <= 1'b0;
      REG_RD <= 1'b0;
      REG_FROM_LINK <= 1'b0;
   endtask

   task automatic pulse(input int i);
      @(posedge CLOCK);
      pls[i] <= 1'b1;
      @(posedge CLOCK);
      pls[i] <= 1'b0;
   endtask

   task automatic wait_hi(input int s);
      int n;
      n = 0;
      while (probe[s] !== 1'b1 && n < 30)
      begin
         @(posedge CLOCK);
         n++;
      end
      cmp_pin({7'h0, probe[s]}, 8'h1);
      if (n >= 30)
         test_done();
   endtask

   // main sequence
   initial
   begin
      logic [31:0] p, d;
      logic        c;
      p = $urandom(32'hA227);
      p = $urandom();
      d = $urandom();
      repeat (5) @(posedge CLOCK);
      RSTN <= 1'b1;
      bus(0, 0, 4'h0, 32'h0);
      bus(0, 0, 4'h9, 32'h0);
      cmp_pin(DEBUG_DATA_OUT, 8'h0);
      bus(1, 1, 4'h1, 32'h0);
      bus(1, 1, 4'h2, p);
      bus(0, 0, 4'h2, p);
      bus(1, 0, 4'h2, 32'h0);
      bus(0, 1, 4'h3, 32'h0);
      bus(0, 1, 4'h1, 32'h5);
      bus(1, 0, 4'h0, 32'h1);
      cmp_pin(DEBUG_DATA_OUT, 8'h2);
      INSN_PC <= p;
      pulse(0);
      wait_hi(0);
      bus(0, 0, 4'h0, 32'h102);
      bus(0, 0, 4'h0, 32'h100);
      bus(0, 1, 4'h0, 32'h10);
      RESET_INPUT_N <= 1'b0;
      pulse(5);
      repeat (3) @(posedge CLOCK);
      cmp_pin({EMU_MODE, CORE_HALT}, 8'h1);
      RESET_INPUT_N <= 1'b1;
      pulse(5);
      wait_hi(1);
      bus(0, 1, 4'h0, 32'h0);
      pulse(4);
      wait_hi(3);
      pulse(1);
      bus(0, 1, 4'h1, 32'h0);
      bus(0, 1, 4'h4, 32'h200);
      bus(0, 1, 4'h5, 32'h20F);
      bus(0, 1, 4'h6, d);
      bus(0, 1, 4'h7, 32'h0);
      bus(0, 1, 4'h1, 32'h8A);
      BUS_ADDR <= 32'h20F;
      BUS_DATA <= ~d;
      pulse(6);
      bus(0, 0, 4'h0, 32'h5);
      bus(0, 0, 4'h0, 32'h5);
      cmp_pin(DEBUG_DATA_OUT, 8'hA);
      BUS_ADDR <= 32'h300;
      BUS_DATA <= d;
      pulse(6);
      IRQ_LEVEL <= 3'h7;
      repeat (4) @(posedge CLOCK);
      cmp_pin({DEBUG_DATA_OUT, EMU_MODE, TAKE_DEBUG_IRQ}, 8'h30);
      pulse(0);
      wait_hi(1);
      repeat (6) @(posedge CLOCK);
      cmp_pin(EXC_VECTOR, 8'h0C);
      cmp_pin(IRQ_ACCEPT, 8'h0);
      bus(0, 0, 4'h0, 32'h86);
      bus(0, 0, 4'h0, 32'h80);
      bus(0, 1, 4'h2, p);
      bus(0, 1, 4'h3, 32'h0);
      bus(0, 1, 4'h1, 32'h6);
      pulse(4);
      wait_hi(3);
      pulse(0);
      repeat (6) @(posedge CLOCK);
      cmp_pin(EMU_MODE, 8'h0);
      pulse(1);
      pulse(0);
      wait_hi(1);
      bus(0, 1, 4'h1, 32'h6);
      bus(0, 0, 4'h0, 32'h81);
      bus(0, 1, 4'h1, 32'h0);
      pulse(4);
      wait_hi(3);
      pulse(1);
      bus(0, 1, 4'h0, 32'h60);
      pulse(3);
      wait_hi(1);
      c = $urandom_range(1, 0);
      ACCESS_IS_CODE <= c;
      @(posedge CLOCK);
      cmp_pin({EMU_SPACE, CACHE_SRAM_OFF, TRANSFER_TYPE, TRANSFER_MODIFIER},
              {4'h0, 2'b11, 2'h2, c ? 3'h6 : 3'h5});
      // entry code must finish before a return is honoured
      repeat (4) @(posedge CLOCK);
      pulse(4);
      wait_hi(3);
      bus(0, 1, 4'h0, 32'h0);
      IRQ_LEVEL <= 3'h0;
      // for each operand size: one instruction, then the operand with its marker
      for (int s = 0; s < 4; s++)
      begin
         d = $urandom();
         pst_x <= 4'h1;
         INSN_PC <= d;
         pulse(1);
         wait_hi(4);
         OPND_SIZE <= s[1:0];
         OPND_DATA <= d;
         dd_x <= d[3:0];
         pst_x <= (s == 0) ? 4'h8 : (s == 1) ? 4'h9 : 4'hB;
         pulse(2);
         wait_hi(4);
         wait_hi(5);
      end
      // memory command waits for the bus to go idle
      DBG_REG_REQ <= 1'b1;
      BUS_IDLE <= 1'b0;
      DBG_MEM_REQ <= 1'b1;
      repeat (4) @(posedge CLOCK);
      cmp_pin({DBG_BUS_GRANT, DBG_REG_OK}, 8'h0);
      BUS_IDLE <= 1'b1;
      wait_hi(2);
      cmp_pin(FETCH_STALL, 8'h1);
      pulse(7);
      DBG_MEM_REQ <= 1'b0;
      DBG_REG_REQ <= 1'b0;
      repeat (10) @(posedge CLOCK);
      cmp_pin(DBG_BUS_GRANT, 8'h0);
      cmp_pin(edges, lm.sent[7:0]);
      test_done();
   end
endmodule
`default_nettype wire
